// [agr_gain_ctrl.sv]
// Gain ramp and mode control of a stereo amplifier.
// Assumes static host control pins synchronous to sys_clk; reset acts as power-up.
// Behaviour
// - Low config select enables negative amps, bridge-tied
// - High config select: negative amps off, single-ended
// - Source select high headphone, low line
// - Source and output selects act independently
// - Run low mutes, enters low-current state
// - Ramp select low ramped, high immediate
// - Ramped shutdown steps gain down every two ticks
// - Step clock nominal 58 Hz, 34 ms steps
// - Ramp spans up to 31 steps
// - Ramped bypass discharge starts only at lowest gain
// - Ramped release: charge bypass, then ramp up
// - Immediate shutdown saves gain, discharges at once
// - Immediate release restores saved gain after charge
// - Power-up ramps from lowest every two ticks
// - Single-ended gain limited by ceiling input
`timescale 1ns/1ps
`default_nettype none
module agr_gain_ctrl #(
	parameter int TICK_DIV = agr_pkg::STEP_TICK_CYCLES,
	parameter int BYPASS_CNT = agr_pkg::BYPASS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire agr_pkg::agr_ctrl_s ctrl,
	input wire logic [4:0] commandedGain,
	input wire logic [4:0] headphone_gain_ceiling,
	output agr_pkg::agr_path_s path,
	output logic [4:0] gainStep,
	output agr_pkg::agr_state_e seqState
);
	import agr_pkg::*;

	logic tick; // Slow step tick
	logic tickPhase; // Counts two ticks per step
	logic [4:0] targetGain; // Limited commanded gain
	logic [4:0] savedGain; // Gain held across immediate shutdown
	logic [31:0] bypassCount; // Bypass settle counter
	logic bypassDone; // Bypass settle finished
	agr_state_e state; // Sequencer state
	agr_state_e next_state; // Next sequencer state
	logic stepNow; // Gain step allowed this cycle
	logic immediateMode; // Shutdown taken in immediate mode

	// ************************************************************
	// Helpers
	// ************************************************************
	// Smaller of two gain codes
	function automatic logic [4:0] gainMin(input logic [4:0] a, input logic [4:0] b);
		gainMin = (a < b) ? a : b;
	endfunction

	// Step tick divider
	agr_tick_div #(.DIV(TICK_DIV)) tickDiv (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(tick)
	);

	// Ceiling applied only in single-ended mode
	assign targetGain = ctrl.outputConfigSelect ? gainMin(commandedGain, headphone_gain_ceiling)
		: commandedGain;

	// Step every second tick
	assign stepNow = tick && tickPhase;
	assign bypassDone = (bypassCount == 32'(BYPASS_CNT - 1));

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Two-tick phase
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tickPhase <= 1'b0;
		end else if (tick) begin
			tickPhase <= ~tickPhase;
		end
	end

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			AGR_POWERUP: begin // Power-up ramp regardless of mode
				if (gainStep == targetGain) begin
					next_state = AGR_RUN;
				end
			end
			AGR_RUN: begin
				if (!ctrl.runEnable) begin
					next_state = ctrl.rampModeSelect ? AGR_DISCHG : AGR_RAMPDN;
				end
			end
			AGR_RAMPDN: begin // Ramp down to lowest first
				if (gainStep == GAIN_MIN) begin
					next_state = AGR_DISCHG;
				end
			end
			AGR_DISCHG: begin
				if (bypassDone) begin
					next_state = AGR_OFF;
				end
			end
			AGR_OFF: begin
				if (ctrl.runEnable) begin
					next_state = AGR_CHARGE;
				end
			end
			AGR_CHARGE: begin
				if (bypassDone) begin
					next_state = immediateMode ? AGR_RUN : AGR_RAMPUP;
				end
			end
			AGR_RAMPUP: begin
				if (gainStep == targetGain) begin
					next_state = AGR_RUN;
				end
			end
			default: begin // Illegal code
				next_state = AGR_POWERUP;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= AGR_POWERUP;
		end else begin
			state <= next_state;
		end
	end

	// Mode latched on shutdown entry
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			immediateMode <= 1'b0;
		end else if (state == AGR_RUN && !ctrl.runEnable) begin
			immediateMode <= ctrl.rampModeSelect;
		end
	end

	// Bypass settle counter, cleared on entry to charge or discharge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bypassCount <= 32'h00000000;
		end else if (state != next_state || bypassDone) begin
			bypassCount <= 32'h00000000;
		end else if (state == AGR_DISCHG || state == AGR_CHARGE) begin
			bypassCount <= bypassCount + 32'h00000001;
		end
	end

	// Saved gain for immediate restore
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			savedGain <= GAIN_MIN;
		end else if (state == AGR_RUN && !ctrl.runEnable && ctrl.rampModeSelect) begin
			savedGain <= gainStep;
		end
	end

	// ************************************************************
	// Gain step register
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gainStep <= GAIN_MIN;
		end else begin
			unique case (state)
				AGR_POWERUP, AGR_RAMPUP: begin // Step up toward target
					if (stepNow && gainStep < targetGain) begin
						gainStep <= gainStep + 5'h01;
					end else if (gainStep > targetGain) begin
						gainStep <= targetGain;
					end
				end
				AGR_RUN: begin // Follow commanded step
					gainStep <= targetGain;
				end
				AGR_RAMPDN: begin // Down one step per two ticks
					if (stepNow && gainStep != GAIN_MIN) begin
						gainStep <= gainStep - 5'h01;
					end
				end
				AGR_CHARGE: begin // Restore or start low after charge
					if (bypassDone) begin
						gainStep <= immediateMode ? savedGain : GAIN_MIN;
					end
				end
				AGR_DISCHG, AGR_OFF: begin // Held low while off
					gainStep <= GAIN_MIN;
				end
				default: begin
					gainStep <= GAIN_MIN;
				end
			endcase
		end
	end

	// ************************************************************
	// Analog path controls
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			path <= '0;
			path.mute <= 1'b1;
		end else begin
			path.mute <= !ctrl.runEnable || state == AGR_DISCHG || state == AGR_OFF
				|| state == AGR_CHARGE;
			path.lowPower <= state == AGR_OFF;
			path.negAmpEnable <= !ctrl.outputConfigSelect && ctrl.runEnable;
			path.selHeadphone <= ctrl.inputSourceSelect && ctrl.runEnable;
			path.selLine <= !ctrl.inputSourceSelect && ctrl.runEnable;
			path.bypassDischarge <= state == AGR_DISCHG;
			path.bypassCharge <= state == AGR_CHARGE;
		end
	end

	assign seqState = state;
endmodule // agr_gain_ctrl
`default_nettype wire

// [agr_host_model.sv]
// Host model driving the static control pins.
// Assumes the bench hands it the wanted pin levels.
`timescale 1ns/1ps
`default_nettype none
module agr_host_model
	import agr_pkg::*;
(
	input wire logic sys_clk,
	input wire agr_pkg::agr_ctrl_s want,
	output agr_pkg::agr_ctrl_s ctrl
);
	// Pins always driven, changed just after the edge
	initial ctrl = 4'h8;
	always @(posedge sys_clk) begin
		ctrl <= want;
	end
endmodule // agr_host_model
`default_nettype wire

// [agr_monitor.sv]
// Checker for the gain ramp and mode control block.
// Assumes binding onto agr_gain_ctrl built with a tick divider of 4.
`timescale 1ns/1ps
`default_nettype none
module agr_monitor
	import agr_pkg::*;
#(
	parameter int TICK_DIV = 4,
	parameter int BYPASS_CNT = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire agr_pkg::agr_ctrl_s ctrl,
	input wire logic [4:0] commandedGain,
	input wire logic [4:0] headphone_gain_ceiling,
	input wire agr_pkg::agr_path_s path,
	input wire logic [4:0] gainStep,
	input wire agr_pkg::agr_state_e seqState
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [4:0] tgt; // Ceiling-limited target
	assign tgt = (ctrl.outputConfigSelect && headphone_gain_ceiling < commandedGain) ? headphone_gain_ceiling
		: commandedGain;
	chk_output_mode: assert property (seqState == AGR_RUN && $past(seqState) == AGR_RUN
		|-> path.negAmpEnable == !$past(ctrl.outputConfigSelect)) else $error("output mode wrong");
	chk_source_route: assert property (seqState == AGR_RUN && $past(seqState) == AGR_RUN
		|-> path.selHeadphone == $past(ctrl.inputSourceSelect) && path.selLine != path.selHeadphone)
		else $error("source route wrong");
	chk_off_muted: assert property (seqState == AGR_OFF |=> path.mute && path.lowPower)
		else $error("off not muted");
	chk_shut_entry: assert property ($fell(ctrl.runEnable) && seqState == AGR_RUN
		|=> path.mute && seqState == ($past(ctrl.rampModeSelect) ? AGR_DISCHG : AGR_RAMPDN))
		else $error("shutdown entry wrong");
	chk_ramp_down: assert property (seqState == AGR_RAMPDN && $changed(gainStep)
		|-> gainStep == $past(gainStep) - 5'h01) else $error("ramp step wrong");
	chk_step_space: assert property (seqState == AGR_RAMPDN && $changed(gainStep)
		|=> ($stable(gainStep) || seqState != AGR_RAMPDN) [*7]) else $error("step too soon");
	chk_floor_first: assert property (seqState == AGR_DISCHG && $past(seqState) == AGR_RAMPDN
		|-> gainStep == GAIN_MIN) else $error("discharge above floor");
	chk_charge_first: assert property (seqState == AGR_RAMPUP && $past(seqState) == AGR_CHARGE
		|-> $past(gainStep) == GAIN_MIN) else $error("ramp up not from floor");
	chk_run_target: assert property (seqState == AGR_RUN && $past(seqState) == AGR_RUN
		&& $stable(commandedGain) && $stable(headphone_gain_ceiling) && $stable(ctrl)
		|-> gainStep == tgt) else $error("run gain wrong");
	chk_powerup_low: assert property ($past(rst) |-> gainStep == GAIN_MIN
		&& seqState == AGR_POWERUP) else $error("power-up not low");
	chk_discharge_on: assert property (seqState == AGR_DISCHG
		|=> path.bypassDischarge && !path.bypassCharge && path.mute) else $error("discharge output wrong");
	chk_charge_on: assert property (seqState == AGR_CHARGE
		|=> path.bypassCharge && !path.bypassDischarge && path.mute) else $error("charge output wrong");
	// Main scenarios reached
	cover property (seqState == AGR_OFF);
	cover property ($past(seqState) == AGR_CHARGE && seqState == AGR_RAMPUP);
	cover property ($past(seqState) == AGR_RUN && seqState == AGR_DISCHG);
	cover property ($past(seqState) == AGR_CHARGE && seqState == AGR_RUN);
endmodule // agr_monitor
bind agr_gain_ctrl agr_monitor #(.TICK_DIV(TICK_DIV), .BYPASS_CNT(BYPASS_CNT)) mon (.sys_clk(sys_clk),
	.rst(rst), .ctrl(ctrl), .commandedGain(commandedGain), .headphone_gain_ceiling(headphone_gain_ceiling),
	.path(path), .gainStep(gainStep), .seqState(seqState));
`default_nettype wire

// [agr_pkg.sv]
// Package for the amplifier gain ramp and mode control block.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
`default_nettype none
package agr_pkg;

	// ************************************************************
	// Timing constants
	// ************************************************************
	localparam int SYS_CLK_HZ = 40000000; // System clock rate
	localparam int STEP_CLK_HZ = 58; // Nominal gain-stepping clock
	localparam int STEP_TICK_CYCLES = SYS_CLK_HZ / STEP_CLK_HZ; // Cycles per step tick, rounded down
	localparam int TICKS_PER_STEP = 2; // Step clock cycles per gain step
	localparam int BYPASS_TIME_MS = 500; // Bypass charge or discharge time
	localparam int BYPASS_CYCLES = (SYS_CLK_HZ / 1000) * BYPASS_TIME_MS; // Bypass settle cycles

	// ************************************************************
	// Gain codes and reset values
	// ************************************************************
	localparam int GAIN_W = 5; // Gain step code width
	localparam logic [4:0] GAIN_MIN = 5'h00; // Lowest gain step
	localparam logic [4:0] GAIN_MAX = 5'h1F; // Highest gain step

	// ************************************************************
	// Types
	// ************************************************************
	// Sequencer states, Gray coded along the usual path
	typedef enum logic [2:0] {
		AGR_POWERUP = 3'h0,
		AGR_RUN = 3'h1,
		AGR_RAMPDN = 3'h3,
		AGR_DISCHG = 3'h2,
		AGR_OFF = 3'h6,
		AGR_CHARGE = 3'h7,
		AGR_RAMPUP = 3'h5
	} agr_state_e;

	// Static control pins from the host
	typedef struct packed {
		logic runEnable; // High while amplifier in use
		logic outputConfigSelect; // High selects single-ended
		logic inputSourceSelect; // High selects headphone inputs
		logic rampModeSelect; // Low ramped, high immediate
	} agr_ctrl_s;

	// Analog path controls
	typedef struct packed {
		logic mute; // Outputs muted
		logic lowPower; // Low-current state
		logic negAmpEnable; // Negative follower amplifiers on
		logic selHeadphone; // Headphone pair routed
		logic selLine; // Line pair routed
		logic bypassCharge; // Charge bypass toward midrail
		logic bypassDischarge; // Discharge bypass toward ground
	} agr_path_s;

endpackage
`default_nettype wire

// [agr_tick_div.sv]
// Divider that makes the slow gain-stepping tick.
// Assumes the sys_clk rate named in the package.
`timescale 1ns/1ps
`default_nettype none
module agr_tick_div #(
	parameter int DIV = agr_pkg::STEP_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	output logic tick
);
	import agr_pkg::*;

	logic [19:0] count; // Cycle counter

	// ************************************************************
	// Divider
	// ************************************************************
	// One-cycle pulse every DIV cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= 20'h00000;
			tick <= 1'b0;
		end else if (count == 20'(DIV - 1)) begin
			count <= 20'h00000;
			tick <= 1'b1;
		end else begin
			count <= count + 20'h00001;
			tick <= 1'b0;
		end
	end
endmodule // agr_tick_div
`default_nettype wire

// [tb_top.sv]
// Testbench for the gain ramp and mode control block.
// Assumes short tick and bypass counts of 4 and 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import agr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	agr_ctrl_s want = 4'h8; // Run high, bridge-tied, line, ramped
	agr_ctrl_s ctrl;
	logic [4:0] cmd = 5'h0A;
	logic [4:0] ceil = 5'h1F;
	logic [4:0] g;
	agr_path_s path;
	logic [4:0] gainStep;
	agr_state_e seqState;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	logic [31:0] seed = 32'h00000045;
	agr_host_model host (.sys_clk(sys_clk), .want(want), .ctrl(ctrl));
	agr_gain_ctrl #(.TICK_DIV(4), .BYPASS_CNT(8)) dut (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl),
		.commandedGain(cmd), .headphone_gain_ceiling(ceil), .path(path), .gainStep(gainStep), .seqState(seqState));
	// ************************************************************
	// Helpers
	// ************************************************************
	initial forever #12.5 sys_clk = ~sys_clk;
	function automatic logic [4:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[4:0];
	endfunction
	function automatic logic [4:0] tgt(logic se, logic [4:0] c, logic [4:0] m);
		return (se && m < c) ? m : c;
	endfunction
	task automatic chk(logic [4:0] seen, logic [4:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Poll at falling edges for a state, bounded
	task automatic wt(agr_state_e s);
		n = 0;
		while (seqState !== s && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(5'(seqState), 5'(s));
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		wt(AGR_RUN);
		chk(gainStep, 5'h0A);
		$display("test 1 done");
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			want.outputConfigSelect <= i[0];
			want.inputSourceSelect <= i[1];
			cmd <= rnd();
			ceil <= rnd();
			repeat (4) @(negedge sys_clk);
			chk({path.mute, path.negAmpEnable, path.selHeadphone, path.selLine}, {1'b0, !i[0], i[1], !i[1]});
			chk(gainStep, tgt(i[0], cmd, ceil));
		end
		$display("test 2 done");
		@(posedge sys_clk);
		want.outputConfigSelect <= 1'b0;
		cmd <= 5'h1F;
		repeat (4) @(posedge sys_clk);
		want.runEnable <= 1'b0;
		wt(AGR_DISCHG);
		chk(5'(n >= 240 && n <= 260), 5'h01);
		wt(AGR_OFF);
		// Path outputs are registered one cycle behind the state
		@(negedge sys_clk);
		chk({path.mute, path.lowPower}, 2'h3);
		@(posedge sys_clk);
		want.runEnable <= 1'b1;
		wt(AGR_RUN);
		chk(gainStep, 5'h1F);
		$display("test 3 done");
		g = rnd() | 5'h01;
		@(posedge sys_clk);
		cmd <= g;
		want.rampModeSelect <= 1'b1;
		repeat (4) @(posedge sys_clk);
		want.runEnable <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(5'(seqState), 5'(AGR_DISCHG));
		wt(AGR_OFF);
		@(posedge sys_clk);
		cmd <= ~g;
		want.runEnable <= 1'b1;
		wt(AGR_RUN);
		chk(gainStep, g);
		$display("test 4 done");
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
